// >>> dv/dip_host_model.sv
// Host bus model: drives the I/O port as host software would.
// Assumes the block takes a request on the rising clock edge.
`timescale 1ns/1ns
module dip_host_model
   import dip_pkg::*;
(
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output dip_io_req_s o_req
);
   // Idle bus until software acts.
   initial o_req = '0;
   // One-cycle write, launched 1 ns after an edge.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk) #1;
      o_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge i_clk) #1;
      o_req.wr = 1'b0;
   endtask : wr
   // One-cycle read; data is registered on the taking edge.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk) #1;
      o_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(posedge i_clk) #1;
      o_req.rd = 1'b0;
      d = i_rdata;
   endtask : rd
   // Both pacer timers in square-wave mode 3, low byte then high byte.
   task automatic pacer(input logic [15:0] d1, input logic [15:0] d2);
      wr(OFS_TIMER_MODE_CONTROL, 8'h76);
      wr(OFS_TIMER_COUNT_1, d1[7:0]);
      wr(OFS_TIMER_COUNT_1, d1[15:8]);
      wr(OFS_TIMER_MODE_CONTROL, 8'hB6);
      wr(OFS_TIMER_COUNT_2, d2[7:0]);
      wr(OFS_TIMER_COUNT_2, d2[15:8]);
   endtask : pacer
endmodule : dip_host_model

// >>> dv/tb.sv
// Self-checking bench of the dual request and pacer block.
// Assumes the host model drives the I/O port; seeded random stimulus.
`timescale 1ns/1ns
module tb;
   import dip_pkg::*;
   logic i_clk = 1'b0, i_nrst = 1'b0, i_adc_result_stored = 1'b0;
   logic i_ext_irq = 1'b0, o_adc_pacer_trigger, o_inta_n, o_inta_n_oe;
   logic [10:0] i_fifo_words = 11'h000;
   logic [7:0] o_io_rdata, rv, rh;
   dip_io_req_s req;
   int n_fail = 0, compares = 0, seed = 32'h9D04371E, dv, t0, t1;
   always #5 i_clk = ~i_clk;
   dip_host_model host(.i_clk(i_clk), .i_rdata(o_io_rdata), .o_req(req));
   dip_dual_irq_pacer uut(.i_clk(i_clk), .i_nrst(i_nrst),
      .i_io_addr(req.addr), .i_io_wr(req.wr), .i_io_rd(req.rd),
      .i_io_wdata(req.wdata), .o_io_rdata(o_io_rdata),
      .i_adc_result_stored(i_adc_result_stored),
      .i_fifo_words(i_fifo_words), .i_ext_irq(i_ext_irq),
      .o_adc_pacer_trigger(o_adc_pacer_trigger), .o_inta_n(o_inta_n),
      .o_inta_n_oe(o_inta_n_oe));
   // Compare one value; an unknown never matches.
   task automatic chk(input logic [15:0] g, e, input string m);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %0t %s", $time, m);
      end
   endtask : chk
   // Pending bits only; the line bit is judged at the pin.
   task automatic st(input logic [7:0] e);
      host.rd(OFS_IRQ_STATUS, rv);
      chk({8'h00, rv & 8'h03}, {8'h00, e}, "status");
   endtask : st
   // Cycle count at the next trigger pulse; a missing pulse fails.
   task automatic trig(output int t);
      for (int k = 0; k < 2000; k++) begin
         @(posedge i_clk) #1;
         if (o_adc_pacer_trigger === 1'b1) break;
      end
      t = $time / 10;
      chk({15'h0, o_adc_pacer_trigger}, 16'h1, "no trigger");
   endtask : trig
   task tally_and_finish;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish
   // Hang guard, well past the thousand or so cycles the tests take.
   initial begin
      #300000 n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (2) @(posedge i_clk);
      #1 i_nrst = 1'b1;
      chk({15'h0, o_inta_n_oe}, 16'h1, "line idle");
      host.rd(OFS_IRQ_SOURCE_SELECT, rv);
      chk({8'h0, rv}, 16'h0, "select reset");
      host.wr(8'h50, 8'hFF);
      host.rd(8'h50, rv);
      chk({8'h0, rv}, 16'h0, "unmapped");
      host.wr(OFS_BRIDGE_IRQ_CTRL, 8'h01);
      @(posedge i_clk) #1 i_adc_result_stored = 1'b1;
      @(posedge i_clk) #1 i_adc_result_stored = 1'b0;
      st(8'h01);
      chk({15'h0, o_inta_n_oe}, 16'h0, "line low");
      chk({15'h0, o_inta_n}, 16'h0, "line level");
      host.wr(OFS_BRIDGE_IRQ_CTRL, 8'h00);
      repeat (2) @(posedge i_clk);
      #1;
      chk({15'h0, o_inta_n_oe}, 16'h1, "gated");
      host.wr(OFS_IRQ_SOURCE_SELECT, 8'h03);
      @(posedge i_clk) #1 i_ext_irq = 1'b1;
      repeat (4) @(posedge i_clk);
      st(8'h03);
      host.wr(OFS_IRQ_STATUS, 8'h01);
      st(8'h02);
      i_fifo_words = 11'($unsigned($random(seed)) % 512);
      st(8'h02);
      i_fifo_words = FIFO_HALF_WORDS - 11'h001;
      st(8'h02);
      @(posedge i_clk) #1 i_fifo_words = FIFO_HALF_WORDS;
      st(8'h03);
      host.wr(OFS_IRQ_STATUS, 8'h03);
      st(8'h00);
      i_ext_irq = 1'b0;
      i_fifo_words = 11'h000;
      host.wr(OFS_IRQ_SOURCE_SELECT, 8'h01);
      host.rd(OFS_TIMER_MODE_CONTROL, rv);
      chk({8'h0, rv}, 16'h0, "control reads zero");
      dv = 2 + ($unsigned($random(seed)) % 2);
      host.pacer(16'(dv), 16'h0002);
      // Latch counter one, then read it low byte first.
      host.wr(OFS_TIMER_MODE_CONTROL, 8'h40);
      host.rd(OFS_TIMER_COUNT_1, rv);
      host.rd(OFS_TIMER_COUNT_1, rh);
      chk({15'h0, ({rh, rv} >= 16'h1) && ({rh, rv} <= 16'(dv))}, 16'h1,
         "latched count");
      trig(t0);
      host.wr(OFS_IRQ_STATUS, 8'h03);
      st(8'h00);
      trig(t0);
      trig(t1);
      chk(16'(t1 - t0), 16'(2 * dv * BASE_DIV), "pacer period");
      st(8'h02);
      tally_and_finish();
   end
endmodule : tb

// >>> rtl/dip_dual_irq_pacer.sv
// Dual interrupt source and pacer timer block of the acquisition card.
// Assumes an 8-bit host I/O port on the system clock; the line pin is
// open drain and the acquisition strobes come from same-clock logic.
//
// Summary of operation
// - Two independent requests may be pending together.
// - Both requests merge onto one interrupt line.
// - First request: conversion done or FIFO half-full.
// - Second request: pacer output or external request.
// - One select bit per request chooses source.
// - Software reads which request is pending.
// - Request held until cleared; software checks other.
// - Bridge enable gates merged line independently.
// - Timers one and two cascade from 2 MHz.
// - Each timer divisor reaches 65536, written as zero.
// - Pacer feeds second request and conversion trigger.
// - Four offsets address counter bytes and control.
// - Half-full means 512 words in the FIFO.
// - Conversion done when result sits in FIFO.
`timescale 1ns/1ns
module dip_dual_irq_pacer
   import dip_pkg::*;
(
   input wire logic i_clk, // System clock, 100 MHz.
   input wire logic i_nrst, // Asynchronous reset, active low.
   input wire logic [7:0] i_io_addr, // Host I/O byte address.
   input wire logic i_io_wr, // Write strobe, one cycle.
   input wire logic i_io_rd, // Read strobe, one cycle.
   input wire logic [7:0] i_io_wdata, // Write data.
   output logic [7:0] o_io_rdata, // Read data, valid after a read.
   input wire logic i_adc_result_stored, // Result written to FIFO.
   input wire logic [10:0] i_fifo_words, // Words held in the FIFO.
   input wire logic i_ext_irq, // External request pin.
   output logic o_adc_pacer_trigger, // Conversion trigger pulse.
   output logic o_inta_n, // Line level when driven.
   output logic o_inta_n_oe // Low while the line is pulled low.
);

   // ****************************************************************
   // Host access decode
   // ****************************************************************
   dip_io_req_s req; // The host access bundled.
   assign req = '{addr: i_io_addr, wr: i_io_wr, rd: i_io_rd,
                  wdata: i_io_wdata};

   // Address match, used by every register of the map.
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   wire sel_ctrl_wr = req.wr & hit(req.addr, OFS_TIMER_MODE_CONTROL);
   wire sel_isc_wr = req.wr & hit(req.addr, OFS_IRQ_SOURCE_SELECT);
   wire sel_st_wr = req.wr & hit(req.addr, OFS_IRQ_STATUS);
   wire sel_brg_wr = req.wr & hit(req.addr, OFS_BRIDGE_IRQ_CTRL);
   wire [1:0] ctrl_counter = req.wdata[7:6]; // Counter addressed.
   wire [1:0] ctrl_rw = req.wdata[5:4]; // Byte access kind.
   wire [2:0] ctrl_mode = req.wdata[3:1]; // Counting mode.

   // ****************************************************************
   // Pin synchroniser and timer base
   // ****************************************************************
   logic ext_meta; // First stage, read only by the second.
   logic ext_sync; // Synchronised external request.
   logic [$clog2(BASE_DIV)-1:0] base_cnt; // Base divider.
   logic base_tick; // One cycle in every BASE_DIV.

   // The external pin is asynchronous, so it passes two flops first.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
      end else begin
         ext_meta <= i_ext_irq;
         ext_sync <= ext_meta;
      end
   end

   // Divide the system clock down to the 2 MHz timer base.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         base_cnt <= '0;
         base_tick <= 1'b0;
      end else begin
         base_tick <= (base_cnt == ($clog2(BASE_DIV))'(BASE_DIV - 1));
         if (base_cnt == ($clog2(BASE_DIV))'(BASE_DIV - 1)) begin
            base_cnt <= '0;
         end else begin
            base_cnt <= base_cnt + 1'b1;
         end
      end
   end

   // ****************************************************************
   // Timer counters with byte-wise access
   // ****************************************************************
   localparam logic [7:0] CNT_OFS [3] = '{OFS_TIMER_COUNT_0,
                                          OFS_TIMER_COUNT_1,
                                          OFS_TIMER_COUNT_2};
   logic [2:0] cnt_out; // Counter outputs.
   logic [2:0] cnt_tick; // Count steps.
   logic [2:0] cnt_hit; // Offset match per counter.
   logic [7:0] cnt_rbyte [3]; // Byte each counter offers on a read.
   logic out1_q; // Counter one output, previous cycle.
   logic out2_q; // Counter two output, previous cycle.
   logic pacer_rise; // Rising edge of the pacer output.

   // Cascade: counter two steps on each rising edge of counter one,
   // so the fastest pacer is the base divided by two times two.
   assign cnt_tick[1] = base_tick;
   assign cnt_tick[2] = cnt_out[1] & ~out1_q;
   // The pre-trigger counter counts conversion triggers.
   assign cnt_tick[0] = o_adc_pacer_trigger;
   assign pacer_rise = cnt_out[2] & ~out2_q;

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_cnt
         logic [1:0] rw; // Byte access kind.
         logic [2:0] mode; // Counting mode.
         logic wr_hi; // Next write takes the high byte.
         logic rd_hi; // Next read gives the high byte.
         logic [7:0] lsb_hold; // Low byte held for the pair.
         logic [15:0] divisor; // Divisor written by software.
         logic [15:0] latched; // Value caught by a latch command.
         logic latch_valid; // Latched value awaits reading.
         logic load; // Divisor complete this cycle.
         logic [15:0] value; // Live count.
         wire ctl = sel_ctrl_wr & (ctrl_counter == 2'(g));
         wire wr = req.wr & cnt_hit[g];
         wire rd = req.rd & cnt_hit[g];
         wire [15:0] shown = latch_valid ? latched : value;
         wire take_hi = (rw == RW_MSB) | ((rw == RW_BOTH) & rd_hi);
         wire [15:0] next_div = (rw == RW_LSB) ? {8'h00, req.wdata}
                              : (rw == RW_MSB) ? {req.wdata, 8'h00}
                              : {req.wdata, lsb_hold};

         assign cnt_hit[g] = hit(req.addr, CNT_OFS[g]);
         assign cnt_rbyte[g] = take_hi ? shown[15:8] : shown[7:0];
         assign load = wr & ((rw != RW_BOTH) | wr_hi);

         // Control byte, byte sequencing and the read latch.
         always_ff @(posedge i_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               rw <= RW_BOTH;
               mode <= MODE_RESET;
               wr_hi <= 1'b0;
               rd_hi <= 1'b0;
               lsb_hold <= 8'h00;
               divisor <= 16'h0000;
               latched <= 16'h0000;
               latch_valid <= 1'b0;
            end else begin
               if (ctl && ctrl_rw == RW_LATCH) begin
                  latched <= value;
                  latch_valid <= 1'b1;
                  rd_hi <= 1'b0;
               end else if (ctl) begin
                  rw <= ctrl_rw;
                  mode <= ctrl_mode;
                  wr_hi <= 1'b0;
                  rd_hi <= 1'b0;
                  latch_valid <= 1'b0;
               end else begin
                  if (wr && rw == RW_BOTH) begin
                     wr_hi <= ~wr_hi;
                  end
                  if (wr && !wr_hi) begin
                     lsb_hold <= req.wdata;
                  end
                  if (load) begin
                     divisor <= next_div;
                  end
                  if (rd && rw == RW_BOTH) begin
                     rd_hi <= ~rd_hi;
                  end
                  // A latched value is released once fully read.
                  if (rd && (rw != RW_BOTH || rd_hi)) begin
                     latch_valid <= 1'b0;
                  end
               end
            end
         end

         dip_timer_counter u_counter (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .i_tick(cnt_tick[g]),
            .i_load(load),
            .i_divisor(next_div),
            .i_mode(mode),
            .o_out(cnt_out[g]),
            .o_value(value)
         );
      end
   endgenerate

   // Edge history and the one-cycle conversion trigger.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         out1_q <= 1'b1;
         out2_q <= 1'b1;
         o_adc_pacer_trigger <= 1'b0;
      end else begin
         out1_q <= cnt_out[1];
         out2_q <= cnt_out[2];
         o_adc_pacer_trigger <= pacer_rise;
      end
   end

   // ****************************************************************
   // Source selection and request latches
   // ****************************************************************
   logic [1:0] irq_source_select_reg; // One bit per request.
   logic bridge_irq_en; // Bridge gate of the merged line.
   logic acq_irq_request; // First request pending.
   logic timer_ext_irq_request; // Second request pending.
   logic line_active; // Registered merged request.

   // Half-full counts whole words already held in the FIFO.
   wire fifo_half = (i_fifo_words >= FIFO_HALF_WORDS);
   // Zero picks the first listed source, one the second.
   wire acq_src = irq_source_select_reg[SEL_ACQ_BIT] ? fifo_half
                : i_adc_result_stored;
   wire tmr_src = irq_source_select_reg[SEL_TMR_BIT] ? ext_sync
                : cnt_out[2];
   wire clr_acq = sel_st_wr & req.wdata[ST_ACQ_BIT];
   wire clr_tmr = sel_st_wr & req.wdata[ST_TMR_BIT];
   wire next_line = bridge_irq_en & (acq_irq_request |
                                     timer_ext_irq_request);

   // Two independent latches so both can be pending together.
   dip_irq_latch u_acq_latch (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_src(acq_src),
      .i_clear(clr_acq),
      .o_pending(acq_irq_request)
   );

   dip_irq_latch u_tmr_latch (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_src(tmr_src),
      .i_clear(clr_tmr),
      .o_pending(timer_ext_irq_request)
   );

   // Select and gate registers, and the single merged line.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_source_select_reg <= SEL_RESET;
         bridge_irq_en <= BRG_EN_RESET;
         line_active <= 1'b0;
      end else begin
         if (sel_isc_wr) begin
            irq_source_select_reg <= req.wdata[1:0];
         end
         if (sel_brg_wr) begin
            bridge_irq_en <= req.wdata[BRG_EN_BIT];
         end
         line_active <= next_line;
      end
   end

   // Open drain: only ever pull low, never drive high.
   assign o_inta_n = 1'b0;
   assign o_inta_n_oe = ~line_active;

   // ****************************************************************
   // Read data
   // ****************************************************************
   logic [7:0] next_rdata; // Byte selected for the current read.
   wire [7:0] status = {5'h00, line_active, timer_ext_irq_request,
                        acq_irq_request};

   // Unmapped offsets and the write-only control byte read as zero.
   always_comb begin
      next_rdata = 8'h00;
      if (cnt_hit[0]) begin
         next_rdata = cnt_rbyte[0];
      end else if (cnt_hit[1]) begin
         next_rdata = cnt_rbyte[1];
      end else if (cnt_hit[2]) begin
         next_rdata = cnt_rbyte[2];
      end else if (hit(req.addr, OFS_IRQ_SOURCE_SELECT)) begin
         next_rdata = {6'h00, irq_source_select_reg};
      end else if (hit(req.addr, OFS_IRQ_STATUS)) begin
         next_rdata = status;
      end else if (hit(req.addr, OFS_BRIDGE_IRQ_CTRL)) begin
         next_rdata = {7'h00, bridge_irq_en};
      end
   end

   // Read data holds until the next read strobe.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_io_rdata <= 8'h00;
      end else if (req.rd) begin
         o_io_rdata <= next_rdata;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_LINE_MERGE: assert property (@(posedge i_clk) disable iff (!i_nrst)
      bridge_irq_en && (acq_irq_request || timer_ext_irq_request)
      |=> !o_inta_n_oe) else $error("pending request not on line");
   AST_LINE_GATE: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !bridge_irq_en |=> o_inta_n_oe) else $error("gated line pulled");
   AST_STATUS_READ: assert property (@(posedge i_clk) disable iff (!i_nrst)
      req.rd && hit(req.addr, OFS_IRQ_STATUS) |=>
      o_io_rdata[1:0] == $past({timer_ext_irq_request, acq_irq_request}))
      else $error("status read wrong");
   AST_PACER_TRIG: assert property (@(posedge i_clk) disable iff (!i_nrst)
      pacer_rise |=> o_adc_pacer_trigger ##1 !o_adc_pacer_trigger)
      else $error("pacer trigger not one pulse");
   AST_HALF_FULL: assert property (@(posedge i_clk) disable iff (!i_nrst)
      irq_source_select_reg[SEL_ACQ_BIT] && !clr_acq &&
      $past(irq_source_select_reg[SEL_ACQ_BIT]) && $past(i_nrst) &&
      i_fifo_words == 11'h200 && $past(i_fifo_words) == 11'h1FF
      |=> acq_irq_request) else $error("half-full missed");
   AST_BASE_RATE: assert property (@(posedge i_clk) disable iff (!i_nrst)
      base_tick |=> !base_tick [*8]) else $error("base tick too fast");

endmodule : dip_dual_irq_pacer

// >>> rtl/dip_irq_latch.sv
// One sticky interrupt request with a rising-edge set and a clear strobe.
// Assumes the source is already on the system clock.
`timescale 1ns/1ns
module dip_irq_latch
   import dip_pkg::*;
(
   input wire logic i_clk, // System clock.
   input wire logic i_nrst, // Asynchronous reset, active low.
   input wire logic i_src, // Selected source level.
   input wire logic i_clear, // One-cycle clear from software.
   output logic o_pending // Request held until cleared.
);

   // ****************************************************************
   // Edge detection and sticky flag
   // ****************************************************************
   logic src_q; // Source seen one cycle earlier.
   logic pending; // Sticky request.
   // Low until the source has been seen once after reset. A source that
   // idles high, such as a rate timer output, would otherwise look like a
   // fresh edge at the first clock and raise a request nobody asked for.
   logic primed;
   wire rise = i_src & ~src_q & primed; // Rising edge of the source.
   // A new edge in the clear cycle wins, so no event is lost.
   wire next_pending = rise | (pending & ~i_clear);

   // Capture the edge and hold the request.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         src_q <= 1'b0;
         pending <= 1'b0;
         primed <= 1'b0;
      end else begin
         src_q <= i_src;
         primed <= 1'b1;
         pending <= next_pending;
      end
   end

   assign o_pending = pending;

   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_LATCH_SET: assert property (@(posedge i_clk) disable iff (!i_nrst)
      rise |=> o_pending) else $error("edge did not set request");
   AST_LATCH_HOLD: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_pending && !i_clear |=> o_pending)
      else $error("request dropped without clear");
   AST_LATCH_CLEAR: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_pending && i_clear && !rise |=> !o_pending)
      else $error("clear did not drop request");

endmodule : dip_irq_latch

// >>> rtl/dip_pkg.sv
// Constants, register map and carrier types of the dual interrupt block.
// Assumes a 100 MHz system clock and an 8-bit host I/O port.
package dip_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int unsigned CLK_HZ = 100_000_000; // System clock rate.
   localparam int unsigned TIMER_BASE_HZ = 2_000_000; // Timer base rate.
   // Cycles of the system clock per timer base tick.
   localparam int unsigned BASE_DIV = CLK_HZ / TIMER_BASE_HZ;

   // ****************************************************************
   // Register offsets on the host I/O port
   // ****************************************************************
   localparam logic [7:0] OFS_TIMER_COUNT_0 = 8'h40; // Counter 0 byte.
   localparam logic [7:0] OFS_TIMER_COUNT_1 = 8'h42; // Counter 1 byte.
   localparam logic [7:0] OFS_TIMER_COUNT_2 = 8'h44; // Counter 2 byte.
   localparam logic [7:0] OFS_TIMER_MODE_CONTROL = 8'h46; // Control.
   localparam logic [7:0] OFS_IRQ_SOURCE_SELECT = 8'h48; // Sources.
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h4A; // Pending, W1C.
   localparam logic [7:0] OFS_BRIDGE_IRQ_CTRL = 8'h4C; // Line gate.

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int unsigned SEL_ACQ_BIT = 0; // Acquisition source bit.
   localparam int unsigned SEL_TMR_BIT = 1; // Timer/external bit.
   localparam int unsigned ST_ACQ_BIT = 0; // Acquisition pending.
   localparam int unsigned ST_TMR_BIT = 1; // Timer/external pending.
   localparam int unsigned ST_LINE_BIT = 2; // Merged line active.
   localparam int unsigned BRG_EN_BIT = 0; // Bridge line enable.
   localparam logic [1:0] SEL_RESET = 2'h0; // First sources chosen.
   localparam logic BRG_EN_RESET = 1'b0; // Line gated off.
   localparam logic [10:0] FIFO_HALF_WORDS = 11'h200; // Half-full.
   localparam logic [1:0] RW_LATCH = 2'h0; // Control: latch count.
   localparam logic [1:0] RW_LSB = 2'h1; // Control: low byte only.
   localparam logic [1:0] RW_MSB = 2'h2; // Control: high byte only.
   localparam logic [1:0] RW_BOTH = 2'h3; // Control: low then high.
   localparam logic [2:0] MODE_RESET = 3'h3; // Square wave mode.

   // One host I/O access, sampled on the system clock.
   typedef struct packed {
      logic [7:0] addr; // Byte address.
      logic wr; // One-cycle write strobe.
      logic rd; // One-cycle read strobe.
      logic [7:0] wdata; // Write data.
   } dip_io_req_s;

endpackage : dip_pkg

// >>> rtl/dip_timer_counter.sv
// One down counter of the programmable timer, in rate, square or one-shot.
// Assumes i_tick is a one-cycle pulse on the system clock.
`timescale 1ns/1ns
module dip_timer_counter
   import dip_pkg::*;
(
   input wire logic i_clk, // System clock.
   input wire logic i_nrst, // Asynchronous reset, active low.
   input wire logic i_tick, // One count step.
   input wire logic i_load, // Divisor complete, restart counting.
   input wire logic [15:0] i_divisor, // Divisor, zero means 65536.
   input wire logic [2:0] i_mode, // Counting mode.
   output logic o_out, // Counter output level.
   output logic [15:0] o_value // Current count.
);

   // ****************************************************************
   // Count state
   // ****************************************************************
   logic [16:0] count; // Seventeen bits so a zero divisor means 65536.
   logic [16:0] reload; // Period in ticks.
   logic armed; // Counting after a load.
   logic out; // Registered output.
   wire periodic = i_mode[1]; // Modes 2 and 3 repeat.
   wire square = i_mode[1] & i_mode[0]; // Mode 3 square wave.
   wire [16:0] next_reload = (i_divisor == 16'h0000) ? 17'h10000
                                                      : {1'b0, i_divisor};
   wire term = armed & i_tick & (count == 17'h00001); // Last step.
   // Square wave stays high for the upper half of the period.
   wire next_out = !armed ? 1'b1
                 : square ? (count > {1'b0, reload[16:1]})
                 : periodic ? (count != 17'h00001)
                 : 1'b0;

   // Count down, reload in the periodic modes, stop in one-shot.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         count <= 17'h00000;
         reload <= 17'h00000;
         armed <= 1'b0;
         out <= 1'b1;
      end else begin
         out <= next_out;
         if (i_load) begin
            reload <= next_reload;
            count <= next_reload;
            armed <= 1'b1;
         end else if (term) begin
            count <= periodic ? reload : 17'h00000;
            armed <= periodic;
         end else if (armed && i_tick) begin
            count <= count - 17'h00001;
         end
      end
   end

   assign o_out = out;
   assign o_value = count[15:0];

   // ****************************************************************
   // Checks
   // ****************************************************************
   AST_TC_RELOAD: assert property (@(posedge i_clk) disable iff (!i_nrst)
      term && periodic && !i_load |=> count == $past(reload))
      else $error("periodic counter did not reload");
   AST_TC_LOAD: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_load |=> armed && count == $past(next_reload))
      else $error("divisor load failed");

endmodule : dip_timer_counter
